//--- shared/fbsc_pkg.sv
package fbsc_pkg;

  // timing
  localparam int CLK_HZ      = 125000000;
  localparam int TICK_MS     = 8;
  localparam int TICK_CYC    = TICK_MS * (CLK_HZ / 1000);
  localparam int SER_BAUD    = 9600;
  localparam int SER_BIT_CYC = CLK_HZ / SER_BAUD;
  localparam int SER_LAST_BIT = 9;

  // message ids and services
  localparam logic [2:0] MSG_ALLOC = 3'h6;
  localparam logic [2:0] MSG_SET   = 3'h4;
  localparam logic [2:0] MSG_PARAM = 3'h6;
  localparam logic [7:0] SVC_ALLOC = 8'h4b;
  localparam logic [7:0] SVC_SET   = 8'h10;

  // classes, instances, attributes
  localparam logic [7:0] CLS_DNET   = 8'h03;
  localparam logic [7:0] CLS_CONN   = 8'h05;
  localparam logic [7:0] CLS_PARAM  = 8'h0f;
  localparam logic [7:0] INST_EXPL  = 8'h01;
  localparam logic [7:0] INST_POLL  = 8'h02;
  localparam logic [7:0] ATTR_NODE  = 8'h01;
  localparam logic [7:0] ATTR_BAUD  = 8'h02;
  localparam logic [7:0] ATTR_ALLOC = 8'h03;
  localparam logic [7:0] ATTR_EPR   = 8'h09;
  localparam logic [7:0] ATTR_PVAL  = 8'h01;

  // field values
  localparam logic [7:0]  ALLOC_EXPL = 8'h01;
  localparam logic [7:0]  ALLOC_BOTH = 8'h03;
  localparam logic [7:0]  BAUD_MAX   = 8'h02;
  localparam logic [1:0]  BAUD_RST   = 2'h0;
  localparam logic [7:0]  NODE_MAX   = 8'h3f;
  localparam logic [5:0]  NODE_RST   = 6'h3f;
  localparam logic [7:0]  PARAM_MODE = 8'h02;
  localparam logic [7:0]  PARAM_MAX  = 8'h0f;
  localparam logic [7:0]  MODE_10    = 8'h0a;
  localparam logic [7:0]  MODE_20    = 8'h14;
  localparam logic [7:0]  MODE_30    = 8'h1e;
  localparam logic [7:0]  MODE_60    = 8'h3c;
  localparam logic [7:0]  MODE_RST   = MODE_60;
  localparam logic [16:0] EPR_ROUND  = 17'h00007;
  localparam int          EPR_SHIFT  = 3;

  typedef enum logic [0:0] {CONN_FREE, CONN_OWNED} fbsc_conn_e;
  typedef enum logic [0:0] {SER_IDLE, SER_SHIFT} fbsc_ser_e;

  typedef struct packed {
    logic        valid;
    logic        unconnected;
    logic [5:0]  src;
    logic [5:0]  dest;
    logic [2:0]  msg;
    logic [7:0]  svc;
    logic [7:0]  cls;
    logic [7:0]  inst;
    logic [7:0]  attr;
    logic [31:0] data;
  } fbsc_req_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] src;
    logic [7:0] outs;
  } fbsc_poll_s;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [5:0]  dest;
    logic [15:0] data;
  } fbsc_rsp_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  inst;
    logic [31:0] value;
  } fbsc_prm_s;

  typedef struct packed {
    logic [13:0] cnt;
    logic        expire;
  } fbsc_wd_s;

endpackage

//--- rtl/fbsc_epr_wdog.sv
`timescale 1ns/1ps
module fbsc_epr_wdog (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // timebase and traffic
  input  wire logic        tick,
  input  wire logic        conn_open,
  input  wire logic        kick,
  input  wire logic [13:0] limit,
  // break
  output logic             expire
);

  fbsc_pkg::fbsc_wd_s st_ff;
  fbsc_pkg::fbsc_wd_s nxt_st;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.expire = 1'b0;
    if (!conn_open || kick || (limit == 14'h0000)) begin
      nxt_st.cnt = 14'h0000;
    end else if (tick) begin
      if ((st_ff.cnt + 14'h0001) >= limit) begin
        nxt_st.expire = 1'b1;
        nxt_st.cnt    = 14'h0000;
      end else begin
        nxt_st.cnt = st_ff.cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign expire = st_ff.expire;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  zero_limit_a: assert property ((limit == 14'h0000) |=> !expire)
    else $error("watchdog expired with timeout disabled");
  kick_clear_a: assert property (kick |=> (st_ff.cnt == 14'h0000) && !expire)
    else $error("kick did not restart the watchdog");

endmodule // fbsc_epr_wdog

//--- rtl/fbsc_conn_ctrl.sv
`timescale 1ns/1ps
module fbsc_conn_ctrl #(
  parameter int TICK_CYC    = fbsc_pkg::TICK_CYC,
  parameter int SER_BIT_CYC = fbsc_pkg::SER_BIT_CYC
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST,
  // explicit requests and answers
  input  wire fbsc_pkg::fbsc_req_s REQ,
  output fbsc_pkg::fbsc_rsp_s      RSP,
  // polled i/o
  input  wire fbsc_pkg::fbsc_poll_s POLL,
  output fbsc_pkg::fbsc_rsp_s      POLL_RSP,
  input  wire logic [9:0]          IN_PINS,
  output logic [7:0]               OUT_PINS,
  // configuration and status
  output logic [5:0]               NODE_ADDR,
  output logic [1:0]               BAUD_SEL,
  output logic [7:0]               MODE,
  output logic                     ALLOCATED,
  output logic                     EXPL_OPEN,
  output logic                     POLL_OPEN,
  output logic                     EPR_BREAK,
  output logic                     DEV_RESET,
  output fbsc_pkg::fbsc_prm_s      PRM_WR,
  // maintenance serial port
  input  wire logic                SER_REQ,
  input  wire logic [7:0]          SER_DATA,
  output logic                     SER_TX,
  output logic                     SER_BUSY
);

  typedef struct packed {
    fbsc_pkg::fbsc_conn_e conn;
    logic [5:0]           owner;
    logic                 expl;
    logic                 poll;
    logic [5:0]           node;
    logic [1:0]           baud;
    logic [13:0]          epr_expl;
    logic [13:0]          epr_poll;
    logic [7:0]           mode;
    logic [7:0]           outs;
    fbsc_pkg::fbsc_rsp_s  rsp;
    fbsc_pkg::fbsc_rsp_s  prsp;
    fbsc_pkg::fbsc_prm_s  prm;
    logic                 brk;
    logic                 dev_reset;
    logic [19:0]          tick_cnt;
    logic                 tick;
    fbsc_pkg::fbsc_ser_e  ser;
    logic [13:0]          ser_cnt;
    logic [3:0]           ser_bit;
    logic [9:0]           ser_shift;
    logic                 ser_tx;
  } fbsc_st_s;

  fbsc_st_s    st_ff;
  fbsc_st_s    nxt_st;
  logic        ours;
  logic        is_alloc;
  logic        is_set;
  logic        is_dnet1;
  logic        is_epr;
  logic        is_prm;
  logic        owner_ok;
  logic        poll_ok;
  logic        mode_ok;
  logic        node_wr;
  logic [7:0]  data0;
  logic [16:0] epr_sum;
  logic [13:0] epr_ticks;
  logic [1:0]  kick;
  logic [1:0]  conn_open;
  logic [1:0]  expire;
  logic [13:0] limit [2];

  // request decode
  assign data0    = REQ.data[7:0];
  assign ours     = REQ.valid && !REQ.unconnected && (REQ.dest == st_ff.node);
  assign is_alloc = (REQ.msg == fbsc_pkg::MSG_ALLOC) && (REQ.svc == fbsc_pkg::SVC_ALLOC)
                    && (REQ.cls == fbsc_pkg::CLS_DNET) && (REQ.inst == fbsc_pkg::INST_EXPL)
                    && (REQ.attr == fbsc_pkg::ATTR_ALLOC);
  assign is_set   = (REQ.msg == fbsc_pkg::MSG_SET) && (REQ.svc == fbsc_pkg::SVC_SET);
  assign is_dnet1 = (REQ.cls == fbsc_pkg::CLS_DNET) && (REQ.inst == fbsc_pkg::INST_EXPL);
  assign is_epr   = is_set && (REQ.cls == fbsc_pkg::CLS_CONN)
                    && (REQ.attr == fbsc_pkg::ATTR_EPR)
                    && ((REQ.inst == fbsc_pkg::INST_EXPL) || (REQ.inst == fbsc_pkg::INST_POLL));
  assign is_prm   = (REQ.msg == fbsc_pkg::MSG_PARAM) && (REQ.svc == fbsc_pkg::SVC_SET)
                    && (REQ.cls == fbsc_pkg::CLS_PARAM) && (REQ.attr == fbsc_pkg::ATTR_PVAL)
                    && (REQ.inst != 8'h00) && (REQ.inst <= fbsc_pkg::PARAM_MAX);
  assign owner_ok = (st_ff.conn == fbsc_pkg::CONN_OWNED) && st_ff.expl
                    && (REQ.src == st_ff.owner);
  assign poll_ok  = POLL.valid && st_ff.poll && (POLL.src == st_ff.owner);
  assign mode_ok  = (data0 == fbsc_pkg::MODE_10) || (data0 == fbsc_pkg::MODE_20)
                    || (data0 == fbsc_pkg::MODE_30) || (data0 == fbsc_pkg::MODE_60);
  assign node_wr  = ours && owner_ok && is_set && is_dnet1 && (REQ.attr == fbsc_pkg::ATTR_NODE)
                    && (data0 <= fbsc_pkg::NODE_MAX);
  // low byte first, rounded up to whole ticks
  assign epr_sum   = {1'b0, REQ.data[15:0]} + fbsc_pkg::EPR_ROUND;
  assign epr_ticks = epr_sum[16:fbsc_pkg::EPR_SHIFT];

  assign kick[0]      = ours && owner_ok;
  assign kick[1]      = poll_ok;
  assign conn_open[0] = st_ff.expl;
  assign conn_open[1] = st_ff.poll;
  assign limit[0]     = st_ff.epr_expl;
  assign limit[1]     = st_ff.epr_poll;

  // one watchdog per connection instance
  for (genvar i = 0; i < 2; i++) begin : g_wdog
    fbsc_epr_wdog u_wdog (
      .clk       (CLK),
      .rst       (RST),
      .tick      (st_ff.tick),
      .conn_open (conn_open[i]),
      .kick      (kick[i]),
      .limit     (limit[i]),
      .expire    (expire[i])
    );
  end

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp.valid = 1'b0;
    nxt_st.rsp.err   = 1'b0;
    nxt_st.prsp.valid = 1'b0;
    nxt_st.prm.valid = 1'b0;
    nxt_st.brk       = 1'b0;
    nxt_st.dev_reset = 1'b0;
    nxt_st.tick      = 1'b0;
    // 8 ms timebase
    if (st_ff.tick_cnt == 20'(TICK_CYC - 1)) begin
      nxt_st.tick_cnt = 20'h00000;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 20'h00001;
    end
    // explicit requests
    if (ours && is_alloc) begin
      if ((st_ff.conn == fbsc_pkg::CONN_FREE) || (REQ.src == st_ff.owner)) begin
        nxt_st.rsp.valid = 1'b1;
        nxt_st.rsp.dest  = REQ.src;
        nxt_st.rsp.data  = 16'h0000;
        if ((data0 == fbsc_pkg::ALLOC_EXPL) || (data0 == fbsc_pkg::ALLOC_BOTH)) begin
          nxt_st.conn  = fbsc_pkg::CONN_OWNED;
          nxt_st.owner = REQ.src;
          nxt_st.expl  = 1'b1;
          nxt_st.poll  = (data0 == fbsc_pkg::ALLOC_BOTH);
        end else begin
          nxt_st.rsp.err = 1'b1;
        end
      end
    end else if (ours && owner_ok) begin
      nxt_st.rsp.valid = 1'b1;
      nxt_st.rsp.dest  = REQ.src;
      nxt_st.rsp.data  = 16'h0000;
      if (is_set && is_dnet1 && (REQ.attr == fbsc_pkg::ATTR_BAUD)
          && (data0 <= fbsc_pkg::BAUD_MAX)) begin
        nxt_st.baud = data0[1:0];
      end else if (is_set && is_dnet1 && (REQ.attr == fbsc_pkg::ATTR_NODE)
                   && (data0 <= fbsc_pkg::NODE_MAX)) begin
        nxt_st.node      = data0[5:0];
        nxt_st.dev_reset = 1'b1;
        nxt_st.conn      = fbsc_pkg::CONN_FREE;
        nxt_st.owner     = 6'h00;
        nxt_st.expl      = 1'b0;
        nxt_st.poll      = 1'b0;
        nxt_st.epr_expl  = 14'h0000;
        nxt_st.epr_poll  = 14'h0000;
        nxt_st.mode      = fbsc_pkg::MODE_RST;
        nxt_st.outs      = 8'h00;
      end else if (is_epr) begin
        if (REQ.inst == fbsc_pkg::INST_EXPL) begin
          nxt_st.epr_expl = epr_ticks;
        end else begin
          nxt_st.epr_poll = epr_ticks;
        end
      end else if (is_prm && (REQ.inst == fbsc_pkg::PARAM_MODE)) begin
        if (mode_ok) begin
          nxt_st.mode = data0;
        end else begin
          nxt_st.rsp.err = 1'b1;
        end
      end else if (is_prm) begin
        nxt_st.prm.valid = 1'b1;
        nxt_st.prm.inst  = REQ.inst;
        nxt_st.prm.value = REQ.data;
      end else begin
        nxt_st.rsp.err = 1'b1;
      end
    end
    // polled i/o
    if (poll_ok && !node_wr) begin
      nxt_st.prsp.valid = 1'b1;
      nxt_st.prsp.err   = 1'b0;
      nxt_st.prsp.dest  = POLL.src;
      nxt_st.prsp.data  = {6'h00, IN_PINS};
      nxt_st.outs = (st_ff.mode == fbsc_pkg::MODE_60) ? POLL.outs : 8'h00;
    end
    // packet rate timeout
    if (expire[0]) begin
      nxt_st.expl = 1'b0;
    end
    if (expire[1]) begin
      nxt_st.poll = 1'b0;
    end
    if (|expire) begin
      nxt_st.outs = 8'h00;
      nxt_st.brk  = 1'b1;
    end
    if (!nxt_st.expl && !nxt_st.poll) begin
      nxt_st.conn = fbsc_pkg::CONN_FREE;
    end
    // maintenance port, 8N1
    case (st_ff.ser)
      fbsc_pkg::SER_IDLE: begin
        nxt_st.ser_tx = 1'b1;
        if (SER_REQ) begin
          nxt_st.ser       = fbsc_pkg::SER_SHIFT;
          nxt_st.ser_shift = {1'b1, SER_DATA, 1'b0};
          nxt_st.ser_tx    = 1'b0;
          nxt_st.ser_cnt   = 14'h0000;
          nxt_st.ser_bit   = 4'h0;
        end
      end
      fbsc_pkg::SER_SHIFT: begin
        if (st_ff.ser_cnt == 14'(SER_BIT_CYC - 1)) begin
          nxt_st.ser_cnt = 14'h0000;
          if (st_ff.ser_bit == 4'(fbsc_pkg::SER_LAST_BIT)) begin
            nxt_st.ser    = fbsc_pkg::SER_IDLE;
            nxt_st.ser_tx = 1'b1;
          end else begin
            nxt_st.ser_bit   = st_ff.ser_bit + 4'h1;
            nxt_st.ser_shift = {1'b1, st_ff.ser_shift[9:1]};
            nxt_st.ser_tx    = st_ff.ser_shift[1];
          end
        end else begin
          nxt_st.ser_cnt = st_ff.ser_cnt + 14'h0001;
        end
      end
      default: begin
        nxt_st.ser    = fbsc_pkg::SER_IDLE;
        nxt_st.ser_tx = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff        <= '0;
      st_ff.conn   <= fbsc_pkg::CONN_FREE;
      st_ff.node   <= fbsc_pkg::NODE_RST;
      st_ff.baud   <= fbsc_pkg::BAUD_RST;
      st_ff.mode   <= fbsc_pkg::MODE_RST;
      st_ff.ser    <= fbsc_pkg::SER_IDLE;
      st_ff.ser_tx <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign RSP       = st_ff.rsp;
  assign POLL_RSP  = st_ff.prsp;
  assign OUT_PINS  = st_ff.outs;
  assign NODE_ADDR = st_ff.node;
  assign BAUD_SEL  = st_ff.baud;
  assign MODE      = st_ff.mode;
  assign ALLOCATED = (st_ff.conn == fbsc_pkg::CONN_OWNED);
  assign EXPL_OPEN = st_ff.expl;
  assign POLL_OPEN = st_ff.poll;
  assign EPR_BREAK = st_ff.brk;
  assign DEV_RESET = st_ff.dev_reset;
  assign PRM_WR    = st_ff.prm;
  assign SER_TX    = st_ff.ser_tx;
  assign SER_BUSY  = (st_ff.ser == fbsc_pkg::SER_SHIFT);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence node_write;
    ours && owner_ok && is_set && is_dnet1 && (REQ.attr == fbsc_pkg::ATTR_NODE)
      && (data0 <= fbsc_pkg::NODE_MAX);
  endsequence
  sequence self_reset;
    DEV_RESET && !ALLOCATED && (OUT_PINS == 8'h00) && (NODE_ADDR == $past(data0[5:0]))
      ##1 !DEV_RESET;
  endsequence
  sequence alloc_free(logic [7:0] ch);
    ours && is_alloc && !ALLOCATED && (data0 == ch) && !(|expire);
  endsequence

  alloc_take_a: assert property (alloc_free(fbsc_pkg::ALLOC_EXPL) |=>
      ALLOCATED && EXPL_OPEN && !POLL_OPEN && RSP.valid && !RSP.err)
    else $error("explicit allocation not taken");
  alloc_both_a: assert property (alloc_free(fbsc_pkg::ALLOC_BOTH) |=>
      EXPL_OPEN && POLL_OPEN)
    else $error("allocation of both connections not taken");
  foreign_drop_a: assert property (REQ.valid && ALLOCATED
      && (REQ.src != st_ff.owner) |=> !RSP.valid)
    else $error("request from a foreign master answered");
  baud_set_a: assert property (ours && owner_ok && is_set && is_dnet1
      && (REQ.attr == fbsc_pkg::ATTR_BAUD) && (data0 <= fbsc_pkg::BAUD_MAX)
      |=> BAUD_SEL == $past(data0[1:0]))
    else $error("baud selection not stored");
  node_reset_a: assert property (node_write |=> self_reset)
    else $error("node address change without self reset");
  epr_round_a: assert property (ours && owner_ok && is_epr
      && (REQ.inst == fbsc_pkg::INST_EXPL) && (REQ.data[15:0] == 16'h0005)
      |=> st_ff.epr_expl == 14'h0001)
    else $error("packet rate not rounded up to one tick");
  break_zero_a: assert property (|expire |=> (OUT_PINS == 8'h00) && EPR_BREAK)
    else $error("outputs not cleared on packet rate timeout");
  poll_break_a: assert property (expire[1] |=> !POLL_OPEN)
    else $error("poll connection survived its timeout");
  uncon_drop_a: assert property (REQ.valid && REQ.unconnected |=> !RSP.valid)
    else $error("unconnected request processed");
  mode_bad_a: assert property (ours && owner_ok && is_prm
      && (REQ.inst == fbsc_pkg::PARAM_MODE) && !mode_ok |=> RSP.err && $stable(MODE))
    else $error("bad mode code accepted");
  mode_pass_a: assert property (poll_ok && (MODE == fbsc_pkg::MODE_60) && !(|expire)
      && !node_wr |=> OUT_PINS == $past(POLL.outs))
    else $error("mode 60 outputs not passed through");
  ser_start_a: assert property (SER_REQ && !SER_BUSY |=> !SER_TX && SER_BUSY)
    else $error("serial start bit missing");

endmodule // fbsc_conn_ctrl

//--- verif/fbsc_master_model.sv
`timescale 1ns/1ps
module fbsc_master_model (
  // clock
  input  wire logic            CLK,
  // requests toward the slave
  output fbsc_pkg::fbsc_req_s  REQ,
  output fbsc_pkg::fbsc_poll_s POLL
);
  initial begin
    REQ  = '0;
    POLL = '0;
  end

  // one request, launched at the falling edge, held one cycle
  task automatic send(input logic [5:0] s, input logic [5:0] d, input logic [2:0] m,
                      input logic [7:0] sv, input logic [7:0] c, input logic [7:0] i,
                      input logic [7:0] a, input logic [31:0] dt, input logic u);
    @(negedge CLK);
    REQ = '{valid: 1'b1, unconnected: u, src: s, dest: d, msg: m, svc: sv, cls: c,
            inst: i, attr: a, data: dt};
    @(negedge CLK);
    REQ = '0;
  endtask

  // allocate both paths at once, sent without checking that the slave is free
  task automatic alloc_both(input logic [5:0] s, input logic [5:0] d);
    send(s, d, 3'h6, 8'h4b, 8'h03, 8'h01, 8'h03, 32'h3, 1'b0);
  endtask

  // poll issued at once, with no wait for allocate, rate or mode
  task automatic poll_out(input logic [5:0] s, input logic [7:0] o);
    @(negedge CLK);
    POLL = '{valid: 1'b1, src: s, outs: o};
    @(negedge CLK);
    POLL = '0;
  endtask
endmodule // fbsc_master_model

//--- verif/fbsc_conn_ctrl_tb.sv
`timescale 1ns/1ps
module fbsc_conn_ctrl_tb;
  logic                 clk;
  logic                 rst;
  fbsc_pkg::fbsc_req_s  req_w;
  fbsc_pkg::fbsc_poll_s poll_w;
  fbsc_pkg::fbsc_rsp_s  rsp;
  fbsc_pkg::fbsc_rsp_s  prsp;
  fbsc_pkg::fbsc_prm_s  prm;
  fbsc_pkg::fbsc_prm_s  prm_last;
  logic [9:0]           in_pins;
  logic [7:0]           out_pins;
  logic [7:0]           mode;
  logic [7:0]           ser_data;
  logic [5:0]           node_addr;
  logic [5:0]           node;
  logic [1:0]           baud;
  logic                 alloc;
  logic                 eopen;
  logic                 popen;
  logic                 brk;
  logic                 dres;
  logic                 dres_seen;
  logic                 ser_req;
  logic                 ser_tx;
  logic                 ser_busy;
  logic [7:0]           o;
  logic [23:0]          expq[$];
  int                   n_fail;
  int                   tests_run;
  int                   cyc;
  int                   n;

  fbsc_master_model fbsc_master_model_i (.CLK(clk), .REQ(req_w), .POLL(poll_w));

  fbsc_conn_ctrl #(.TICK_CYC(10), .SER_BIT_CYC(4)) fbsc_conn_ctrl_i (
    .CLK(clk), .RST(rst), .REQ(req_w), .RSP(rsp), .POLL(poll_w), .POLL_RSP(prsp),
    .IN_PINS(in_pins), .OUT_PINS(out_pins), .NODE_ADDR(node_addr), .BAUD_SEL(baud),
    .MODE(mode), .ALLOCATED(alloc), .EXPL_OPEN(eopen), .POLL_OPEN(popen),
    .EPR_BREAK(brk), .DEV_RESET(dres), .PRM_WR(prm), .SER_REQ(ser_req),
    .SER_DATA(ser_data), .SER_TX(ser_tx), .SER_BUSY(ser_busy));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // e: 0 no answer, 1 good answer, 2 error answer
  task automatic req(input logic [5:0] s, input logic [2:0] m, input logic [7:0] sv,
                     input logic [7:0] c, input logic [7:0] i, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] e);
    if (e != 2'h0) expq.push_back({1'b0, e[1], s, 16'h0});
    fbsc_master_model_i.send(s, node, m, sv, c, i, a, d, 1'b0);
    repeat (2) @(negedge clk);
  endtask

  task automatic do_poll(input logic [5:0] s, input logic [7:0] ov);
    in_pins = 10'($urandom);
    expq.push_back({1'b1, 1'b0, s, 6'h0, in_pins});
    fbsc_master_model_i.poll_out(s, ov);
    @(negedge clk);
  endtask

  // answer watcher, oldest note first
  always @(negedge clk) begin
    if (prm.valid) prm_last = prm;
    if (dres) dres_seen = 1'b1;
    if (rsp.valid || prsp.valid) begin
      if (expq.size() == 0) begin
        check(32'h1, 32'h0);
      end else if (rsp.valid) begin
        check({8'h0, 1'b0, rsp.err, rsp.dest, rsp.data}, {8'h0, expq.pop_front()});
      end else begin
        check({8'h0, 1'b1, prsp.err, prsp.dest, prsp.data}, {8'h0, expq.pop_front()});
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    rst = 1'b1;
    in_pins = 10'h0;
    ser_req = 1'b0;
    ser_data = 8'h0;
    dres_seen = 1'b0;
    node = 6'h3f;
    void'($urandom(17420));
    repeat (16) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    check({baud, mode, node_addr}, {2'h0, 8'h3c, 6'h3f});
    req(6'h01, 3'h4, 8'h10, 8'h03, 8'h01, 8'h02, 32'h1, 2'h0);
    req(6'h01, 3'h6, 8'h4b, 8'h03, 8'h01, 8'h03, 32'h2, 2'h2);
    req(6'h01, 3'h6, 8'h4b, 8'h03, 8'h01, 8'h03, 32'h1, 2'h1);
    check({alloc, eopen, popen}, 3'h6);
    expq.push_back({2'b00, 6'h01, 16'h0});
    fbsc_master_model_i.alloc_both(6'h01, node);
    repeat (2) @(negedge clk);
    check({alloc, eopen, popen}, 3'h7);
    req(6'h02, 3'h4, 8'h10, 8'h03, 8'h01, 8'h02, 32'h1, 2'h0);
    fbsc_master_model_i.send(6'h01, node, 3'h4, 8'h10, 8'h03, 8'h01, 8'h02, 32'h1, 1'b1);
    repeat (2) @(negedge clk);
    check(baud, 2'h0);
    for (int b = 0; b < 4; b++) begin
      req(6'h01, 3'h4, 8'h10, 8'h03, 8'h01, 8'h02, b, (b < 3) ? 2'h1 : 2'h2);
      check(baud, (b < 3) ? b : 2);
    end
    req(6'h01, 3'h6, 8'h10, 8'h07, 8'h01, 8'h01, 32'h0, 2'h2);
    for (int k = 0; k < 5; k++) begin
      logic [7:0] m;
      m = (k == 4) ? 8'h28 : ((k == 3) ? 8'h3c : 8'h0a * (k + 1));
      req(6'h01, 3'h6, 8'h10, 8'h0f, 8'h02, 8'h01, m, (k < 4) ? 2'h1 : 2'h2);
      check(mode, (k < 4) ? m : 8'h3c);
      o = 8'($urandom) | 8'h01;
      do_poll(6'h01, o);
      check(out_pins, (k >= 3) ? o : 8'h0);
    end
    req(6'h01, 3'h6, 8'h10, 8'h0f, 8'h05, 8'h01, 32'h04030201, 2'h1);
    check({prm_last.inst, prm_last.value}, {8'h05, 32'h04030201});
    req(6'h01, 3'h4, 8'h10, 8'h05, 8'h01, 8'h09, 32'h0, 2'h1);
    req(6'h01, 3'h4, 8'h10, 8'h05, 8'h02, 8'h09, 32'hff000009, 2'h1);
    do_poll(6'h01, 8'hff);
    n = 0;
    while (!brk && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(n >= 11 && n <= 20, 1'b1);
    check({out_pins, popen, eopen, alloc}, {8'h0, 3'b011});
    repeat (60) @(negedge clk);
    check(eopen, 1'b1);
    req(6'h01, 3'h4, 8'h10, 8'h03, 8'h01, 8'h01, 32'h40, 2'h2);
    req(6'h01, 3'h4, 8'h10, 8'h03, 8'h01, 8'h01, 32'h05, 2'h1);
    check({dres_seen, node_addr, alloc, mode, baud}, {1'b1, 6'h05, 1'b0, 8'h3c, 2'h2});
    node = 6'h05;
    expq.push_back({2'b00, 6'h02, 16'h0});
    fbsc_master_model_i.alloc_both(6'h02, node);
    repeat (2) @(negedge clk);
    check(alloc, 1'b1);
    req(6'h02, 3'h4, 8'h10, 8'h05, 8'h01, 8'h09, 32'h5, 2'h1);
    repeat (10) @(negedge clk);
    check({eopen, popen}, 2'b01);
    ser_data = 8'($urandom);
    ser_req = 1'b1;
    @(negedge clk) ser_req = 1'b0;
    n = 0;
    while (ser_tx && n < 10) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check({ser_tx, ser_busy}, 2'b01);
    for (int i = 0; i < 9; i++) begin
      repeat (4) @(negedge clk);
      check(ser_tx, (i < 8) ? ser_data[i] : 1'b1);
    end
    repeat (8) @(negedge clk);
    check(ser_busy, 1'b0);
    check(expq.size(), 32'h0);
    report_and_stop();
  end
endmodule // fbsc_conn_ctrl_tb
